// >>> e1_global_consts.svh
// register map, field positions, reset values and timing constants of the global control bank
`ifndef E1_GLOBAL_CONSTS_SVH
`define E1_GLOBAL_CONSTS_SVH

// ==========================================================
// bus geometry
`define ADDR_W           12
`define DATA_W           8

// ==========================================================
// register offsets
`define REG_MONITOR      12'h005
`define REG_GPIO         12'h006
`define REG_REFCLK       12'h007
`define REG_IRQ_SUMMARY  12'h009
`define REG_TIMER_EN     12'h00A
`define REG_TIMER_FLAG   12'h00B
`define REG_CNT_ACCESS   12'h00E
`define REG_CNT_DATA     12'h00F

// ==========================================================
// field positions
`define MON_LO           0
`define MON_HI           3
`define MON_TX_BIT       3
`define DIR_LO           0
`define DIR_HI           1
`define LEVEL_LO         2
`define LEVEL_HI         3
`define RO1_LO           0
`define RO1_HI           2
`define RO2_LO           3
`define RO2_HI           5
`define TIMER_BIT        0
`define CADDR_LO         0
`define CADDR_HI         3
`define CLINK_LO         5
`define CLINK_HI         7

// ==========================================================
// reset values and the monitor off code
`define MON_RST          4'h0
`define DIR_RST          2'h3
`define LEVEL_RST        2'h0
`define PICK_RST         3'h0
`define CADDR_RST        4'h0
`define TAP_OFF          3'h0

// ==========================================================
// timing
`define SECOND_NS        1000000000
`define CLK_PERIOD_NS    10
`define TIMER_W          32

`endif

// >>> e1_global_pkg.sv
// types shared by the global control bank and its helpers
package e1_global_pkg;

    typedef struct packed
    {
        logic       rx_en;     // receiver of the chosen link bridged to link 1
        logic       tx_en;     // transmitter of the chosen link bridged to link 1
        logic [2:0] link;      // zero-based link index
    } tap_route_type;

    typedef enum logic [3:0]
    {
        CNT_CRC,
        CNT_FRAMING,
        CNT_ALIGN_CHANGE,
        CNT_OUT_OF_FRAME,
        CNT_PATTERN,
        CNT_LINE_CODE,
        CNT_TX_CRC,
        CNT_FAR_END,
        CNT_TX_FAR_END
    } counter_kind_type;

    typedef struct packed
    {
        logic [2:0]       link;       // counter_link_pick, zero-based
        logic [3:0]       addr;       // indirect address
        counter_kind_type kind;       // decoded counter
        logic             high_byte;  // upper byte of a two-byte counter
    } counter_sel_type;

    typedef struct packed
    {
        logic [3:0]      tap_select;
        logic [1:0]      dir;
        logic [1:0]      level;
        logic [2:0]      refclk_a_link_pick;
        logic [2:0]      refclk_b_link_pick;
        logic            second_tick_irq_enable;
        logic            second_tick_flag;
        logic [31:0]     tcnt;
        counter_sel_type csel;
        tap_route_type   tap;
        logic [1:0]      gpio_out;
        logic [1:0]      gpio_oe;
        logic            ref_a;
        logic            ref_b;
        logic            irq;
        logic [7:0]      rdata;
    } regs_type;

endpackage

// >>> bit_sync.sv
// two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
`default_nettype none

module bit_sync
#(
    parameter int W = 1
)
(
    input  wire logic         i_clk,     // sampling clock
    input  wire logic         i_rst_n,   // async reset, active low
    input  wire logic [W-1:0] i_d,       // asynchronous levels
    output var  logic [W-1:0] o_q        // synchronised levels
);

    typedef struct packed
    {
        logic [W-1:0] meta;
        logic [W-1:0] safe;
    } sync_type;

    sync_type r_ff;
    sync_type nxt_r;

    // first stage feeds only the second
    always_comb
    begin
        nxt_r.meta = i_d;
        nxt_r.safe = r_ff.meta;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            r_ff <= '0;
        else
            r_ff <= nxt_r;
    end

    assign o_q = r_ff.safe;

endmodule

`default_nettype wire

// >>> e1_global_control_regs.sv
// global control and status register bank of the eight-link E1 transceiver
//
// Contract
// RULE1: monitor select 0000 or 1000 routes nothing to link 1.
// RULE2: top bit clear, low bits k nonzero: receiver of link k+1 bridged.
// RULE3: top bit set, low bits k nonzero: transmitter of link k+1 bridged.
// RULE4: direction bit 0 makes pin output, 1 input; both reset to 1.
// RULE5: output pin drives its value bit; value bit stays read/write.
// RULE6: input pin: value bit reads pin level, host writes ignored.
// RULE7: reference B carries recovered clock of its picked link without loss.
// RULE8: reference A carries recovered clock of its picked link without loss.
// RULE9: on loss, reference gives master clock or high per link config.
// RULE10: eight read-only bits show a pending interrupt in each link.
// RULE11: free-running one-second timer sets a flag at each second.
// RULE12: writing 1 clears the flag; host acknowledges every expiry.
// RULE13: flag raises interrupt only while its enable bit is 1.
// RULE14: three-bit selector picks the link whose counters are reached.
// RULE15: four-bit address picks one of sixteen indirect counter bytes.
// RULE16: address map assigns the nine counters to their bytes.
// RULE17: read-only data register returns the chosen counter byte.
// RULE18: host writes selector first, then reads data, low byte before high.
// RULE19: reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "e1_global_consts.svh"

module e1_global_control_regs
#(
    parameter int unsigned SECOND_CYCLES = `SECOND_NS / `CLK_PERIOD_NS
)
(
    input  wire logic                          i_clk,                  // 100 MHz device clock
    input  wire logic                          i_rst_n,                // async reset, active low
    input  wire logic [`ADDR_W-1:0]            i_addr,                 // register address
    input  wire logic [`DATA_W-1:0]            i_wdata,                // write data
    input  wire logic                          i_wr,                   // write strobe
    input  wire logic                          i_rd,                   // read strobe
    output var  logic [`DATA_W-1:0]            o_rdata,                // read data, cycle after strobe
    output var  e1_global_pkg::tap_route_type  o_tap,                  // line monitor routing
    input  wire logic [1:0]                    i_gpio_in,              // general pin levels
    output var  logic [1:0]                    o_gpio_out,             // general pin drive value
    output var  logic [1:0]                    o_gpio_oe,              // general pin drive enable
    input  wire logic [7:0]                    i_rec_clk,              // recovered clock per link
    input  wire logic [7:0]                    i_los,                  // loss of signal per link
    input  wire logic [7:0]                    i_ref_hold_high_on_loss,// per-link loss behaviour
    input  wire logic                          i_mclk,                 // master clock
    output var  logic                          o_ref_clock_out_a,      // reference clock A
    output var  logic                          o_ref_clock_out_b,      // reference clock B
    input  wire logic [7:0]                    i_link_irq_pending,     // per-link interrupt level
    output var  logic                          o_irq,                  // timer interrupt, active high
    output var  e1_global_pkg::counter_sel_type o_counter_sel,         // performance counter select
    input  wire logic [7:0]                    i_counter_read_value    // selected counter byte
);

    import e1_global_pkg::*;

    // ==========================================================
    // reset release and pin synchronisers
    logic        rst_n_s;
    logic [1:0]  gpio_s;
    logic [7:0]  rec_s;
    logic [7:0]  los_s;
    logic [7:0]  hold_s;
    logic        mclk_s;
    logic [7:0]  link_irq_s;

    bit_sync #(.W(1)) u_rst_sync
    (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_d     (1'b1),
        .o_q     (rst_n_s)
    );

    // recovered clocks are oversampled; edges jitter by one 10 ns period
    bit_sync #(.W(35)) u_pin_sync
    (
        .i_clk   (i_clk),
        .i_rst_n (rst_n_s),
        .i_d     ({i_gpio_in, i_rec_clk, i_los, i_ref_hold_high_on_loss, i_mclk, i_link_irq_pending}),
        .o_q     ({gpio_s, rec_s, los_s, hold_s, mclk_s, link_irq_s})
    );

    // ==========================================================
    // helpers
    function automatic logic pick_ref(input logic [2:0] sel,
                                      input logic [7:0] clk,
                                      input logic [7:0] los,
                                      input logic [7:0] hold,
                                      input logic       mclk);
        logic res;
        res = clk[sel];
        if (los[sel])
            res = hold[sel] ? 1'b1 : mclk;
        return res;
    endfunction

    function automatic counter_kind_type decode_counter(input logic [3:0] a);
        counter_kind_type k;
        k = CNT_CRC;
        unique case (a[3:1])
            3'h0: k = CNT_CRC;
            3'h1: k = CNT_FRAMING;
            3'h2: k = a[0] ? CNT_OUT_OF_FRAME : CNT_ALIGN_CHANGE;
            3'h3: k = CNT_PATTERN;
            3'h4: k = CNT_LINE_CODE;
            3'h5: k = CNT_TX_CRC;
            3'h6: k = CNT_FAR_END;
            3'h7: k = CNT_TX_FAR_END;
        endcase
        return k;
    endfunction

    // ==========================================================
    // state
    regs_type r_ff;
    regs_type nxt_r;
    logic     sec_done;
    logic     wr_gpio;
    logic     wr_flag;

    assign sec_done = (r_ff.tcnt == `TIMER_W'(SECOND_CYCLES - 1));
    assign wr_gpio  = i_wr && (i_addr == `REG_GPIO);
    assign wr_flag  = i_wr && (i_addr == `REG_TIMER_FLAG) && i_wdata[`TIMER_BIT];

    always_comb
    begin
        nxt_r = r_ff;

        // register writes; reserved bits are never stored (see RULE19)
        if (i_wr)
        begin
            unique case (i_addr)
                `REG_MONITOR:
                    nxt_r.tap_select = i_wdata[`MON_HI:`MON_LO];
                `REG_GPIO:
                    nxt_r.dir = i_wdata[`DIR_HI:`DIR_LO];                              // see RULE4
                `REG_REFCLK:
                begin
                    nxt_r.refclk_a_link_pick = i_wdata[`RO1_HI:`RO1_LO];
                    nxt_r.refclk_b_link_pick = i_wdata[`RO2_HI:`RO2_LO];
                end
                `REG_TIMER_EN:
                    nxt_r.second_tick_irq_enable = i_wdata[`TIMER_BIT];
                `REG_CNT_ACCESS:
                begin
                    nxt_r.csel.link = i_wdata[`CLINK_HI:`CLINK_LO];                    // see RULE14
                    nxt_r.csel.addr = i_wdata[`CADDR_HI:`CADDR_LO];                    // see RULE15
                end
                default:
                    nxt_r.tap_select = r_ff.tap_select;
            endcase
        end

        // value bits take a write only while their pin is an output
        for (int i = 0; i < 2; i++)
        begin
            if (wr_gpio && !r_ff.dir[i])
                nxt_r.level[i] = i_wdata[`LEVEL_LO + i];                               // see RULE5
        end

        // free-running second timer; a tick beats a clear in the same cycle
        nxt_r.tcnt = sec_done ? '0 : r_ff.tcnt + `TIMER_W'(1);                         // see RULE11
        if (wr_flag)
            nxt_r.second_tick_flag = 1'b0;                                             // see RULE12
        if (sec_done)
            nxt_r.second_tick_flag = 1'b1;                                             // see RULE11

        // registered outputs
        nxt_r.tap.rx_en = (r_ff.tap_select[2:0] != `TAP_OFF) && !r_ff.tap_select[`MON_TX_BIT]; // see RULE1 RULE2
        nxt_r.tap.tx_en = (r_ff.tap_select[2:0] != `TAP_OFF) && r_ff.tap_select[`MON_TX_BIT];  // see RULE1 RULE3
        nxt_r.tap.link  = r_ff.tap_select[2:0];                                        // see RULE2 RULE3
        nxt_r.gpio_oe   = ~r_ff.dir;                                                   // see RULE4
        nxt_r.gpio_out  = r_ff.level;                                                  // see RULE5
        nxt_r.ref_a     = pick_ref(r_ff.refclk_a_link_pick, rec_s, los_s, hold_s, mclk_s); // see RULE8 RULE9
        nxt_r.ref_b     = pick_ref(r_ff.refclk_b_link_pick, rec_s, los_s, hold_s, mclk_s); // see RULE7 RULE9
        nxt_r.irq       = r_ff.second_tick_flag && r_ff.second_tick_irq_enable;        // see RULE13
        nxt_r.csel.kind      = decode_counter(r_ff.csel.addr);                         // see RULE16
        nxt_r.csel.high_byte = r_ff.csel.addr[0] && (r_ff.csel.addr[3:1] != 3'h2);     // see RULE16

        // read data live only in the cycle after the strobe
        nxt_r.rdata = '0;
        if (i_rd)
        begin
            unique case (i_addr)
                `REG_MONITOR:
                    nxt_r.rdata = {4'h0, r_ff.tap_select};                             // see RULE19
                `REG_GPIO:
                    for (int i = 0; i < 2; i++)
                    begin
                        nxt_r.rdata[`DIR_LO + i]   = r_ff.dir[i];
                        nxt_r.rdata[`LEVEL_LO + i] = r_ff.dir[i] ? gpio_s[i] : r_ff.level[i]; // see RULE6
                    end
                `REG_REFCLK:
                    nxt_r.rdata = {2'h0, r_ff.refclk_b_link_pick, r_ff.refclk_a_link_pick};
                `REG_IRQ_SUMMARY:
                    nxt_r.rdata = link_irq_s;                                          // see RULE10
                `REG_TIMER_EN:
                    nxt_r.rdata = {7'h00, r_ff.second_tick_irq_enable};
                `REG_TIMER_FLAG:
                    nxt_r.rdata = {7'h00, r_ff.second_tick_flag};
                `REG_CNT_ACCESS:
                    nxt_r.rdata = {r_ff.csel.link, 1'b0, r_ff.csel.addr};
                `REG_CNT_DATA:
                    nxt_r.rdata = i_counter_read_value;                                // see RULE17
                default:
                    nxt_r.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            r_ff                        <= '0;
            r_ff.tap_select             <= `MON_RST;
            r_ff.dir                    <= `DIR_RST;                                   // see RULE4
            r_ff.level                  <= `LEVEL_RST;
            r_ff.refclk_a_link_pick     <= `PICK_RST;
            r_ff.refclk_b_link_pick     <= `PICK_RST;
            r_ff.csel.addr              <= `CADDR_RST;
            r_ff.csel.kind              <= CNT_CRC;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign o_rdata           = r_ff.rdata;
    assign o_tap             = r_ff.tap;
    assign o_gpio_out        = r_ff.gpio_out;
    assign o_gpio_oe         = r_ff.gpio_oe;
    assign o_ref_clock_out_a = r_ff.ref_a;
    assign o_ref_clock_out_b = r_ff.ref_b;
    assign o_irq             = r_ff.irq;
    assign o_counter_sel     = r_ff.csel;

    // ==========================================================
    // assertions
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!rst_n_s);

    tap_off_a: assert property ((r_ff.tap_select[2:0] == 3'h0) |=> (!o_tap.rx_en && !o_tap.tx_en)) // see RULE1
        else $error("monitor route active while select is off");

    tap_rx_a: assert property ((!r_ff.tap_select[3] && r_ff.tap_select[2:0] != 3'h0)                  // see RULE2
                               |=> (o_tap.rx_en && !o_tap.tx_en && o_tap.link == $past(r_ff.tap_select[2:0])))
        else $error("receiver route wrong");

    tap_tx_a: assert property ((r_ff.tap_select[3] && r_ff.tap_select[2:0] != 3'h0)                   // see RULE3
                               |=> (o_tap.tx_en && !o_tap.rx_en && o_tap.link == $past(r_ff.tap_select[2:0])))
        else $error("transmitter route wrong");

    gpio_dir_a: assert property ((i_wr && i_addr == `REG_GPIO) |=> ##1 (o_gpio_oe == ~$past(i_wdata[1:0], 2))) // see RULE4
        else $error("pin direction does not follow its bit");

    gpio_drive_a: assert property ((!r_ff.dir[0] && wr_gpio) |=> ##1 (o_gpio_out[0] == $past(i_wdata[2], 2))) // see RULE5
        else $error("output pin not driven from written value");

    gpio_in_ro_a: assert property ((i_rd && i_addr == `REG_GPIO && r_ff.dir[1]) |=> (o_rdata[3] == $past(gpio_s[1]))) // see RULE6
        else $error("input pin level not returned");

    ref_b_clock_a: assert property ((!los_s[r_ff.refclk_b_link_pick]) |=> (o_ref_clock_out_b == $past(rec_s[r_ff.refclk_b_link_pick]))) // see RULE7
        else $error("reference B not the picked recovered clock");

    ref_a_hold_a: assert property ((los_s[r_ff.refclk_a_link_pick] && hold_s[r_ff.refclk_a_link_pick]) |=> o_ref_clock_out_a) // see RULE9
        else $error("reference A not held high on loss");

    irq_summary_a: assert property ((i_rd && i_addr == `REG_IRQ_SUMMARY) |=> (o_rdata == $past(link_irq_s))) // see RULE10
        else $error("link interrupt summary wrong");

    timer_flag_a: assert property (sec_done |=> (r_ff.second_tick_flag && r_ff.tcnt == '0)) // see RULE11
        else $error("second tick missing");

    flag_clear_a: assert property ((wr_flag && !sec_done) |=> !r_ff.second_tick_flag) // see RULE12
        else $error("flag not cleared by write of one");

    irq_gate_a: assert property ((r_ff.second_tick_flag && !r_ff.second_tick_irq_enable) |=> !o_irq) // see RULE13
        else $error("masked timer interrupt raised");

    cnt_data_a: assert property ((i_rd && i_addr == `REG_CNT_DATA) |=> (o_rdata == $past(i_counter_read_value))) // see RULE17
        else $error("counter data not returned");

    rsvd_zero_a: assert property ((i_rd && i_addr == `REG_MONITOR) |=> (o_rdata[7:4] == 4'h0)) // see RULE19
        else $error("reserved bits not zero");

    tick_seen_c: cover property (sec_done ##1 o_irq);
    tap_tx_c:    cover property (o_tap.tx_en);
    gpio_out_c:  cover property (o_gpio_oe[0] && o_gpio_out[0]);
    ref_loss_c:  cover property (los_s[r_ff.refclk_a_link_pick] ##1 o_ref_clock_out_a);

endmodule

`default_nettype wire

// >>> e1_link_side_model.sv
// far-side model of the links: recovered clocks, master clock and counter bytes
`timescale 1ns/1ps
`default_nettype none

module e1_link_side_model
(
    input  wire e1_global_pkg::counter_sel_type i_sel,     // counter byte pick
    input  wire logic                           i_clk,     // device clock
    output var  logic [7:0]                     o_rec_clk, // recovered clock per link
    output var  logic                           o_mclk,    // master clock
    output var  logic [7:0]                     o_value    // picked counter byte
);
    import e1_global_pkg::*;

    logic [8:0] cnt_ff = 9'h000;

    // byte mixes link and address so a wrong pick cannot read back right
    assign o_value   = {i_sel.link, 1'b1, i_sel.addr} ^ 8'h5A;
    // each link gets its own waveform so a wrong clock pick shows
    assign o_rec_clk = cnt_ff[8:1] ^ cnt_ff[7:0];
    assign o_mclk    = cnt_ff[0];

    always_ff @(posedge i_clk)
        cnt_ff <= cnt_ff + 9'h001;
endmodule

`default_nettype wire

// >>> e1_global_control_regs_bench.sv
// self-checking bench of the global control bank against the link model
`timescale 1ns/1ps
`default_nettype none
`include "e1_global_consts.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end

module e1_global_control_regs_bench;
    import e1_global_pkg::*;

    localparam int SEC = 60;
    logic            clk      = 1'b0;
    logic            rst_n    = 1'b0;
    logic [11:0]     addr     = 12'h000;
    logic [7:0]      wdata    = 8'h00;
    logic            wr       = 1'b0;
    logic            rd       = 1'b0;
    logic [1:0]      gpio_in  = 2'h0;
    logic [7:0]      los      = 8'h00;
    logic [7:0]      hold     = 8'h00;
    logic [7:0]      irq_pend = 8'h00;
    logic [7:0]      rdata;
    tap_route_type   tap;
    logic [1:0]      gpio_out;
    logic [1:0]      gpio_oe;
    logic [7:0]      rec_clk;
    logic            mclk;
    logic            ref_a;
    logic            ref_b;
    logic            irq;
    counter_sel_type csel;
    logic [7:0]      cval;
    logic [31:0]     seed     = 32'h0000004A;
    logic [31:0]     v;
    logic [7:0]      exp_q[$];
    logic [7:0]      exp_v;
    logic            rd_seen  = 1'b0;
    logic            ref_chk  = 1'b0;
    logic [2:0]      pa       = 3'h0;
    logic [2:0]      pb       = 3'h0;
    logic [24:0]     hist[0:2];
    logic [3:0]      kind;
    int              n;
    int              mismatches  = 0;
    int              check_count = 0;

    always #5 clk = ~clk;

    e1_global_control_regs #(.SECOND_CYCLES(SEC)) e1_global_control_regs_i
    (
        .i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_tap(tap), .i_gpio_in(gpio_in), .o_gpio_out(gpio_out), .o_gpio_oe(gpio_oe),
        .i_rec_clk(rec_clk), .i_los(los), .i_ref_hold_high_on_loss(hold), .i_mclk(mclk),
        .o_ref_clock_out_a(ref_a), .o_ref_clock_out_b(ref_b), .i_link_irq_pending(irq_pend),
        .o_irq(irq), .o_counter_sel(csel), .i_counter_read_value(cval)
    );

    e1_link_side_model e1_link_side_model_i
    (
        .i_sel(csel), .i_clk(clk), .o_rec_clk(rec_clk), .o_mclk(mclk), .o_value(cval)
    );

    // ==========================================================
    // helpers
    function automatic logic [31:0] nx();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // history word: {mclk, hold, los, rec}
    function automatic logic ref_exp(input logic [24:0] h, input logic [2:0] p);
        return h[8 + p] ? (h[16 + p] ? 1'b1 : h[24]) : h[p];
    endfunction

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    task automatic tally_and_finish();
        if (mismatches == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ==========================================================
    // output watcher: read data one cycle after the strobe, refs three cycles behind pins
    always @(posedge clk)
    begin
        if (rd_seen)
        begin
            exp_v = exp_q.pop_front();
            `CHK(rdata, exp_v)
        end
        rd_seen <= rd;
        if (ref_chk)
        begin
            `CHK(ref_a, ref_exp(hist[2], pa))
            `CHK(ref_b, ref_exp(hist[2], pb))
        end
        hist[2] <= hist[1];
        hist[1] <= hist[0];
        hist[0] <= {mclk, hold, los, rec_clk};
    end

    initial
    begin
        #100000;
        mismatches++;
        tally_and_finish();
    end

    // ==========================================================
    // scenarios
    initial
    begin
        tick(8);
        rst_n <= 1'b1;
        tick(4);
        rd_reg(`REG_MONITOR, 8'h00);
        rd_reg(`REG_GPIO, 8'h03);
        `CHK(gpio_oe, 2'h0)
        rd_reg(`REG_REFCLK, 8'h00);
        rd_reg(`REG_TIMER_EN, 8'h00);
        rd_reg(`REG_CNT_ACCESS, 8'h00);
        for (int c = 0; c < 16; c++)
        begin
            v = nx();
            wr_reg(`REG_MONITOR, {v[7:4], c[3:0]});
            tick(3);
            `CHK(tap, {c[3] == 1'b0 && c[2:0] != 3'h0, c[3] && c[2:0] != 3'h0, c[2:0]})
            rd_reg(`REG_MONITOR, {4'h0, c[3:0]});
        end
        for (int k = 0; k < 6; k++)
        begin
            v = nx();
            gpio_in <= v[9:8];
            wr_reg(`REG_GPIO, {v[7:4], 2'h0, v[1:0]});
            wr_reg(`REG_GPIO, v[7:0]);
            tick(3);
            `CHK(gpio_oe, ~v[1:0])
            `CHK(gpio_out & ~v[1:0], v[3:2] & ~v[1:0])
            rd_reg(`REG_GPIO, {4'h0, (v[9:8] & v[1:0]) | (v[3:2] & ~v[1:0]), v[1:0]});
        end
        // clock picks under random loss and hold-high settings
        for (int k = 0; k < 5; k++)
        begin
            v = nx();
            ref_chk <= 1'b0;
            los     <= v[15:8];
            hold    <= v[23:16];
            pa      <= v[2:0];
            pb      <= v[5:3];
            wr_reg(`REG_REFCLK, v[7:0]);
            tick(6);
            ref_chk <= 1'b1;
            tick(30);
            rd_reg(`REG_REFCLK, {2'h0, v[5:0]});
        end
        ref_chk <= 1'b0;
        for (int a = 0; a < 16; a++)
        begin
            v = nx();
            kind = a < 4 ? a[4:1] : (a < 6 ? a[3:0] - 4'h2 : a[4:1] + 4'h1);
            wr_reg(`REG_CNT_ACCESS, {v[2:0], v[3], a[3:0]});
            rd_reg(`REG_CNT_DATA, {v[2:0], 1'b1, a[3:0]} ^ 8'h5A);
            #1;
            `CHK(csel, {v[2:0], a[3:0], kind, a[0] && a != 4 && a != 5})
            rd_reg(`REG_CNT_ACCESS, {v[2:0], 1'b0, a[3:0]});
        end
        v = nx();
        irq_pend <= v[7:0];
        wr_reg(`REG_IRQ_SUMMARY, ~v[7:0]);
        tick(3);
        rd_reg(`REG_IRQ_SUMMARY, v[7:0]);
        rd_reg(12'h008, 8'h00);
        rd_reg(12'hFFF, 8'h00);
        // one-second flag with and without its interrupt enable
        // stale flag cleared first so the irq edge marks a fresh tick
        wr_reg(`REG_TIMER_FLAG, 8'h01);
        wr_reg(`REG_TIMER_EN, 8'hFF);
        rd_reg(`REG_TIMER_EN, 8'h01);
        n = 0;
        while (irq !== 1'b1 && n < SEC + 10)
        begin
            tick(1);
            n++;
        end
        `CHK(irq, 1'b1)
        rd_reg(`REG_TIMER_FLAG, 8'h01);
        wr_reg(`REG_TIMER_FLAG, 8'h01);
        tick(2);
        #1;
        `CHK(irq, 1'b0)
        rd_reg(`REG_TIMER_FLAG, 8'h00);
        wr_reg(`REG_TIMER_EN, 8'h00);
        n = 0;
        repeat (SEC + 5)
        begin
            tick(1);
            if (irq !== 1'b0)
                n++;
        end
        `CHK(n, 0)
        rd_reg(`REG_TIMER_FLAG, 8'h01);
        tick(4);
        tally_and_finish();
    end
endmodule

`default_nettype wire
